// ===== hw/cec_top.v
// Purpose: can error detection and fault confinement with an apb register port
// Assumes: protocol engine supplies bit_tick, field code and bits, all on pclk
// Notes:   bus level 1 is recessive, can_tx is registered
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cec_regs.vh"
// What this block does
// RULE1: after five equal transmitted bits, send one complement stuff bit.
// RULE2: receivers drop every stuff bit before the frame is interpreted.
// RULE3: six equal bits on the bus within a frame raise a stuff error.
// RULE4: receiver flags crc error when computed and carried checksums differ.
// RULE5: dominant level where the frame demands recessive raises a form error.
// RULE6: transmitter flags ack error when nobody drives the ack slot dominant.
// RULE7: transmit and receive counters rise on errors, fall on successes.
// RULE8: transmit error increase exceeds success decrease, so that counter grows near 1/8 failures; receive steps are equal.
// RULE9: reset places the node in error active state.
// RULE10: error active node drives a dominant error flag, aborting the frame.
// RULE11: node is error active only while both counters are below 128.
// RULE12: either counter above 127 moves the node to error passive.
// RULE13: error passive node sends a recessive error flag.
// RULE14: passive node with ack error keeps its transmit counter unchanged.
// RULE15: transmit counter above 255 moves the node to bus off.
// RULE16: bus off node neither sends nor receives and drives nothing.
// RULE17: only a restart command leaves bus off, clearing both counters.
// RULE18: in length, data and crc fields, sent and sampled levels must match.
// RULE19: ack slot sent recessive; error-free receivers drive it dominant.
// RULE20: an aborted transmission is retried from start of frame.
// RULE21: transmit counter plus eight minus one; receive counter plus one minus one.
module cec_top (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// protocol engine side
	input  wire        bit_tick,
	input  wire [2:0]  field,
	input  wire        frame_tx,
	input  wire        tx_bit,
	input  wire        crc_check,
	input  wire [14:0] crc_calc,
	input  wire [14:0] crc_rx,
	input  wire        frame_done,
	output wire        tx_hold,
	output wire        rx_valid,
	output reg         frame_abort,
	output reg         retx_req,
	// bus
	input  wire        rx_bit,
	output reg         can_tx
);
	localparam ST_ACTIVE  = `CEC_ST_ACTIVE;
	localparam ST_PASSIVE = `CEC_ST_PASSIVE;
	localparam ST_BUSOFF  = `CEC_ST_BUSOFF;
	localparam [`CEC_ERR_W-1:0] ERRS_RST = `CEC_ERRS_RST;

	// apb state
	reg                   enable;
	reg                   restart;
	reg  [`CEC_ERR_W-1:0] errs;
	wire                  setup;
	wire                  access;
	wire                  wr;
	wire                  sel_ctrl;
	wire                  sel_status;
	wire                  sel_count;
	wire                  sel_errs;
	genvar                gi;

	// frame state
	reg  [2:0]            flag_cnt;
	reg                   flag_level;
	reg                   frame_bad;
	reg                   tx_was;
	reg                   next_can_tx;

	// counter interface
	wire [8:0]            tec;
	wire [7:0]            rec;
	wire [1:0]            state;
	wire                  busoff;
	wire                  live;

	// stuff interface
	wire                  stuff_en;
	wire                  stuff_slot;
	wire                  stuff_level;
	wire                  stuff_err;

	// error events
	wire                  ev_bit;
	wire                  ev_stuff;
	wire                  ev_crc;
	wire                  ev_form;
	wire                  ev_ack;
	wire [`CEC_ERR_W-1:0] ev_vec;
	wire                  any_err;
	wire                  flagging;

	function in_field;
		input [2:0] f;
		input [2:0] want;
		begin
			in_field = (f == want);
		end
	endfunction

	function reg_hit;
		input [11:0] a;
		input [11:0] want;
		begin
			reg_hit = (a == want);
		end
	endfunction

	assign busoff   = (state == ST_BUSOFF);
	assign flagging = (flag_cnt != 3'h0);
	// nothing is detected while bus off, disabled or sending a flag
	assign live     = enable & !busoff & !flagging;                 // [RULE16]

	// stuffing covers start of frame through crc
	assign stuff_en = live & (in_field(field, `CEC_FLD_ARB) | in_field(field, `CEC_FLD_CHK));

	// stuff tracking on the bus stream
	cec_stuff u_stuff (
		.pclk        (pclk),
		.presetn     (presetn),
		.bit_tick    (bit_tick),
		.stuff_en    (stuff_en),
		.rx_bit      (rx_bit),
		.stuff_slot  (stuff_slot),
		.stuff_level (stuff_level),
		.stuff_err   (stuff_err)
	);

	// engine holds its next bit during a stuff slot
	assign tx_hold  = frame_tx & stuff_slot;                        // [RULE1]
	// stuff bits never reach the engine as data
	assign rx_valid = bit_tick & live & !stuff_slot;                // [RULE2] [RULE16]

	// error detection at the sample point
	assign ev_bit   = bit_tick & live & frame_tx & in_field(field, `CEC_FLD_CHK)
	                & (rx_bit != can_tx);                           // [RULE18]
	assign ev_stuff = live & stuff_err;                             // [RULE3]
	assign ev_crc   = crc_check & live & !frame_tx & (crc_calc != crc_rx); // [RULE4]
	assign ev_form  = bit_tick & live & !rx_bit
	                & (in_field(field, `CEC_FLD_CRCDEL) | in_field(field, `CEC_FLD_ACKDEL)
	                | in_field(field, `CEC_FLD_EOF));               // [RULE5]
	assign ev_ack   = bit_tick & live & frame_tx & in_field(field, `CEC_FLD_ACK)
	                & rx_bit;                                       // [RULE6]

	assign ev_vec   = {ev_ack, ev_form, ev_crc, ev_stuff, ev_bit};
	assign any_err  = |ev_vec;

	// counters and confinement state
	cec_count u_count (
		.pclk    (pclk),
		.presetn (presetn),
		.tx_err  (any_err & frame_tx),
		.tx_ok   (frame_done & frame_tx & !frame_bad & live),
		.ack_err (ev_ack),
		.rx_err  (any_err & !frame_tx),
		.rx_ok   (frame_done & !frame_tx & !frame_bad & live),
		.restart (restart),
		.tec     (tec),
		.rec     (rec),
		.state   (state)
	);

	// abort and retry pulses, one cycle after an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_abort <= 1'b0;
			retx_req    <= 1'b0;
		end else begin
			frame_abort <= any_err;
			// failed transmission restarts from start of frame
			retx_req    <= any_err & frame_tx;                      // [RULE20]
		end
	end

	// error flag sequencing, counted in bus bits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_cnt    <= 3'h0;
			flag_level  <= 1'b1;
			tx_was      <= 1'b0;
		end else begin
			if (any_err) begin
				flag_cnt   <= `CEC_FLAG_BITS;
				// active sends dominant, passive recessive
				flag_level <= (state == ST_PASSIVE);            // [RULE10] [RULE13]
				tx_was     <= frame_tx;
			end else if (bit_tick && flagging) begin
				flag_cnt <= flag_cnt - 3'h1;
			end
		end
	end

	// a frame with an error is neither acknowledged nor counted as a success
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			frame_bad <= 1'b0;
		else if (busoff || in_field(field, `CEC_FLD_IDLE))
			frame_bad <= 1'b0;
		else if (any_err)
			frame_bad <= 1'b1;
	end

	// bus drive, registered
	always @* begin
		next_can_tx = 1'b1;
		if (!enable || busoff) begin
			next_can_tx = 1'b1;                                     // [RULE16]
		end else if (flagging) begin
			next_can_tx = flag_level;                               // [RULE10] [RULE13]
		end else if (in_field(field, `CEC_FLD_ACK)) begin
			// sender leaves the slot recessive, clean receivers pull it low
			next_can_tx = frame_tx | frame_bad;                     // [RULE19]
		end else if (frame_tx && !in_field(field, `CEC_FLD_IDLE)) begin
			next_can_tx = stuff_slot ? stuff_level : tx_bit;        // [RULE1]
		end
	end

	// recessive during reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			can_tx <= 1'b1;
		else
			can_tx <= next_can_tx;
	end

	// apb slave, no wait states
	assign setup  = psel & !penable;
	assign access = psel & penable;
	assign wr     = access & pwrite & !pslverr;
	assign pready = access;

	// register selects, full address compare
	assign sel_ctrl   = reg_hit(paddr, `CEC_ADDR_CTRL);
	assign sel_status = reg_hit(paddr, `CEC_ADDR_STATUS);
	assign sel_count  = reg_hit(paddr, `CEC_ADDR_COUNT);
	assign sel_errs   = reg_hit(paddr, `CEC_ADDR_ERRS);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
			if (sel_ctrl) begin
				prdata[`CEC_CTRL_ENABLE] <= enable;
			end else if (sel_status) begin
				prdata[`CEC_STAT_STATE_HI:`CEC_STAT_STATE_LO] <= state;
				prdata[`CEC_STAT_FLAG]  <= flagging;
				prdata[`CEC_STAT_TXING] <= tx_was;
			end else if (sel_count) begin
				prdata[`CEC_CNT_TEC_HI:`CEC_CNT_TEC_LO] <= tec;
				prdata[`CEC_CNT_REC_HI:`CEC_CNT_REC_LO] <= rec;
			end else if (sel_errs) begin
				prdata[`CEC_ERR_W-1:0] <= errs;
			end else begin
				pslverr <= 1'b1;
			end
		end
	end

	// control register, restart is a one-cycle pulse
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable  <= `CEC_CTRL_RST;
			restart <= 1'b0;
		end else begin
			restart <= wr & sel_ctrl & pwdata[`CEC_CTRL_RESTART]; // [RULE17]
			if (wr && sel_ctrl)
				enable <= pwdata[`CEC_CTRL_ENABLE];
		end
	end

	// sticky error bits, a new event beats a clear
	generate
		for (gi = 0; gi < `CEC_ERR_W; gi = gi + 1) begin : g_err
			// one flop per error kind, write one to clear
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					errs[gi] <= ERRS_RST[gi];
				else if (wr && sel_errs && pwdata[gi])
					errs[gi] <= ev_vec[gi];
				else
					errs[gi] <= errs[gi] | ev_vec[gi];
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== hw/cec_regs.vh
// Purpose: constants for the can error confinement block
// Assumes: included by bare name from every design file that holds a module
// Notes:   offsets are byte addresses on the register bus
`ifndef CEC_REGS_VH
`define CEC_REGS_VH

// register byte offsets
`define CEC_ADDR_CTRL      12'h000
`define CEC_ADDR_STATUS    12'h004
`define CEC_ADDR_COUNT     12'h008
`define CEC_ADDR_ERRS      12'h00c

// control fields
`define CEC_CTRL_RESTART   0
`define CEC_CTRL_ENABLE    1
`define CEC_CTRL_RST       1'b1

// status fields
`define CEC_STAT_STATE_LO  0
`define CEC_STAT_STATE_HI  1
`define CEC_STAT_FLAG      2
`define CEC_STAT_TXING     3

// count fields
`define CEC_CNT_TEC_LO     0
`define CEC_CNT_TEC_HI     8
`define CEC_CNT_REC_LO     16
`define CEC_CNT_REC_HI     23

// error bits, sticky, write one to clear
`define CEC_ERR_BIT        0
`define CEC_ERR_STUFF      1
`define CEC_ERR_CRC        2
`define CEC_ERR_FORM       3
`define CEC_ERR_ACK        4
`define CEC_ERR_W          5
`define CEC_ERRS_RST       5'h00

// confinement states
`define CEC_ST_ACTIVE      2'h0
`define CEC_ST_PASSIVE     2'h1
`define CEC_ST_BUSOFF      2'h2

// frame field codes from the protocol engine
`define CEC_FLD_IDLE       3'h0
`define CEC_FLD_ARB        3'h1
`define CEC_FLD_CHK        3'h2
`define CEC_FLD_CRCDEL     3'h3
`define CEC_FLD_ACK        3'h4
`define CEC_FLD_ACKDEL     3'h5
`define CEC_FLD_EOF        3'h6

// bit stream and counter figures
`define CEC_STUFF_RUN      3'h5
`define CEC_FLAG_BITS      3'h6
`define CEC_PASSIVE_LIM    9'h07f
`define CEC_BUSOFF_LIM     9'h0ff
`define CEC_TEC_INC        9'h008
`define CEC_TEC_DEC        9'h001
`define CEC_REC_INC        8'h01
`define CEC_REC_DEC        8'h01
`define CEC_REC_MAX        8'hff
`define CEC_TEC_RST        9'h000
`define CEC_REC_RST        8'h00

`endif

// ===== hw/cec_stuff.v
// Purpose: stuff bit tracking on the bus bit stream
// Assumes: bit_tick marks the sample point, rx_bit is the sampled bus level
// Notes:   the stuff bit itself opens the next run
`timescale 1ns/1ns
`default_nettype none
`include "cec_regs.vh"
module cec_stuff (
	// clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// bit stream
	input  wire       bit_tick,
	input  wire       stuff_en,
	input  wire       rx_bit,
	// stuff status
	output wire       stuff_slot,
	output wire       stuff_level,
	output wire       stuff_err
);
	reg [2:0] run;
	reg       last;

	// five equal bits make the next bit a complement
	assign stuff_slot  = stuff_en & (run == `CEC_STUFF_RUN);  // [RULE1] [RULE2]
	assign stuff_level = ~last;                                // [RULE1]
	// a sixth equal bit in a stuff slot
	assign stuff_err   = bit_tick & stuff_slot & (rx_bit == last); // [RULE3]

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run  <= 3'h0;
			last <= 1'b1;
		end else if (bit_tick) begin
			if (!stuff_en) begin
				run  <= 3'h0;
				last <= 1'b1;
			end else if (stuff_slot || rx_bit != last || run == 3'h0) begin
				run  <= 3'h1;
				last <= rx_bit;
			end else begin
				run <= run + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== hw/cec_count.v
// Purpose: transmit and receive error counters and confinement state
// Assumes: event inputs are one-cycle pulses, at most one of each per cycle
// Notes:   transmit counter freezes once bus off is reached
`timescale 1ns/1ns
`default_nettype none
`include "cec_regs.vh"
module cec_count (
	// clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// events
	input  wire       tx_err,
	input  wire       tx_ok,
	input  wire       ack_err,
	input  wire       rx_err,
	input  wire       rx_ok,
	input  wire       restart,
	// state
	output reg  [8:0] tec,
	output reg  [7:0] rec,
	output reg  [1:0] state
);
	localparam ST_ACTIVE  = `CEC_ST_ACTIVE;
	localparam ST_PASSIVE = `CEC_ST_PASSIVE;
	localparam ST_BUSOFF  = `CEC_ST_BUSOFF;

	reg [8:0] next_tec;
	reg [7:0] next_rec;
	reg [1:0] next_state;

	always @* begin
		next_tec   = tec;
		next_rec   = rec;
		next_state = state;
		case (state)
			ST_BUSOFF: begin
				if (restart) begin
					next_tec   = `CEC_TEC_RST;              // [RULE17]
					next_rec   = `CEC_REC_RST;              // [RULE17]
					next_state = ST_ACTIVE;                 // [RULE17]
				end
			end
			default: begin
				// passive node ignores ack errors on the transmit count
				if (tx_err && !(state == ST_PASSIVE && ack_err))  // [RULE14]
					next_tec = tec + `CEC_TEC_INC;          // [RULE7] [RULE8] [RULE21]
				else if (tx_ok && tec != 9'h000)
					next_tec = tec - `CEC_TEC_DEC;          // [RULE7] [RULE21]
				if (rx_err && rec != `CEC_REC_MAX)
					next_rec = rec + `CEC_REC_INC;          // [RULE7] [RULE21]
				else if (rx_ok && rec != 8'h00)
					next_rec = rec - `CEC_REC_DEC;          // [RULE7] [RULE21]
				if (next_tec > `CEC_BUSOFF_LIM)
					next_state = ST_BUSOFF;                 // [RULE15]
				else if (next_tec > `CEC_PASSIVE_LIM || {1'b0, next_rec} > `CEC_PASSIVE_LIM)
					next_state = ST_PASSIVE;                // [RULE12]
				else
					next_state = ST_ACTIVE;                 // [RULE11]
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tec   <= `CEC_TEC_RST;
			rec   <= `CEC_REC_RST;
			state <= ST_ACTIVE;                             // [RULE9]
		end else begin
			tec   <= next_tec;
			rec   <= next_rec;
			state <= next_state;
		end
	end
endmodule
`default_nettype wire

// ===== hw/cec_pad.v
// Purpose: none
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== test/cec_chk.sv
// Purpose: port-level checks for the error confinement block
// Assumes: bound to cec_top from the bench top file
// Notes:   error events are judged only at live bit ticks
`timescale 1ns/1ns
`default_nettype none
`include "cec_regs.vh"
module cec_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// engine side
	input wire logic        bit_tick,
	input wire logic [2:0]  field,
	input wire logic        frame_tx,
	input wire logic        crc_check,
	input wire logic [14:0] crc_calc,
	input wire logic [14:0] crc_rx,
	input wire logic        tx_hold,
	input wire logic        rx_valid,
	input wire logic        frame_abort,
	input wire logic        retx_req,
	// bus
	input wire logic        rx_bit,
	input wire logic        can_tx
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RETX_ABORT: assert property (retx_req |-> frame_abort)
		else $error("retry request without abort");
	AST_ABORT_ONCE: assert property (frame_abort |=> !frame_abort)
		else $error("abort pulse longer than one cycle");
	AST_FLAG_QUIET: assert property (frame_abort |-> !rx_valid [*6])
		else $error("bit accepted during error flag");
	AST_RXV_TICK: assert property (rx_valid |-> bit_tick && !tx_hold)
		else $error("valid bit outside a plain bit tick");
	AST_HOLD_TX: assert property (tx_hold |-> frame_tx)
		else $error("stuff hold while not sending");
	AST_CRC_ERR: assert property (crc_check && rx_valid && !frame_tx && crc_calc != crc_rx
		|=> frame_abort && !retx_req)
		else $error("checksum mismatch not flagged");
	AST_ACK_ERR: assert property (rx_valid && frame_tx && field == `CEC_FLD_ACK && rx_bit
		|=> frame_abort && retx_req)
		else $error("missing acknowledge not flagged");
	AST_FORM_ERR: assert property (rx_valid && !rx_bit && (field == `CEC_FLD_CRCDEL
		|| field == `CEC_FLD_ACKDEL || field == `CEC_FLD_EOF) |=> frame_abort)
		else $error("dominant delimiter not flagged");
	AST_BIT_ERR: assert property (rx_valid && frame_tx && field == `CEC_FLD_CHK
		&& rx_bit != can_tx |=> frame_abort)
		else $error("sent and seen levels differ unflagged");
	cover property (retx_req);
	cover property (tx_hold && bit_tick);
	cover property (rx_valid && field == `CEC_FLD_ACK && !frame_tx);
endmodule
`default_nettype wire

// ===== test/cec_node.sv
// Purpose: the other node on the shared bus
// Assumes: bus is wired-and with a recessive pull-up
// Notes:   drv is the other node's own level, set by the bench
`timescale 1ns/1ns
`default_nettype none
`include "cec_regs.vh"
module cec_node (
	// bus
	input  wire logic       can_tx,
	input  wire logic       drv,
	output wire logic       rx_bit,
	// frame view
	input  wire logic [2:0] field,
	input  wire logic       frame_tx,
	input  wire logic       ack_en
);
	// acks a frame it took cleanly, otherwise releases the slot
	assign rx_bit = can_tx & drv & ~(ack_en & frame_tx & (field == `CEC_FLD_ACK));
endmodule
`default_nettype wire

// ===== test/tb_can_error_confinement.sv
// Purpose: self-checking bench for the error confinement block
// Assumes: bit ticks every four clocks, apb reads checked by a monitor
// Notes:   counter figures are tracked in te and re
`timescale 1ns/1ns
`default_nettype none
`include "cec_regs.vh"
module tb_can_error_confinement;
	localparam [32:0] all_m = 33'h1ffffffff;
	localparam [32:0] st_m  = 33'h3;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, r;
	logic        bit_tick = 0, frame_tx = 0, tx_bit = 1, crc_check = 0, frame_done = 0;
	logic [2:0]  field = 0;
	logic [14:0] crc_calc = 0, crc_rx = 0;
	logic        drv = 1, ack_en = 1, hold_s, rxv_s, tx_s;
	wire         pready, pslverr, tx_hold, rx_valid, frame_abort, retx_req, rx_bit, can_tx;
	wire  [31:0] prdata;
	logic [32:0] qe[$], qm[$];
	int          miscompares = 0, compares = 0, te = 0, re = 0, old;

	always #2 pclk = ~pclk;

	cec_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bit_tick(bit_tick), .field(field), .frame_tx(frame_tx),
		.tx_bit(tx_bit), .crc_check(crc_check), .crc_calc(crc_calc), .crc_rx(crc_rx),
		.frame_done(frame_done), .tx_hold(tx_hold), .rx_valid(rx_valid),
		.frame_abort(frame_abort), .retx_req(retx_req), .rx_bit(rx_bit), .can_tx(can_tx));
	cec_node u_node (.can_tx(can_tx), .drv(drv), .rx_bit(rx_bit), .field(field),
		.frame_tx(frame_tx), .ack_en(ack_en));

	task stop_test;
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task cmp(input [32:0] g, input [32:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e, input [32:0] m);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		if (!w) begin
			qe.push_back(e);
			qm.push_back(m);
		end
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			stop_test;
		end
		psel <= 0;
		penable <= 0;
	endtask

	task rd(input [11:0] a, input [32:0] e, input [32:0] m);
		apb(0, a, 0, e, m);
	endtask

	task wr(input [11:0] a, input [31:0] d);
		apb(1, a, d, 0, 0);
	endtask

	// one bus bit: field, sending, engine bit, other node level, checksum strobe
	task bt(input [2:0] f, input t, input b, input d, input c);
		@(posedge pclk);
		field <= f;
		frame_tx <= t;
		tx_bit <= b;
		drv <= d;
		repeat (2) @(posedge pclk);
		bit_tick <= 1;
		crc_check <= c;
		#1;
		hold_s = tx_hold;
		rxv_s = rx_valid;
		tx_s = can_tx;
		@(posedge pclk);
		bit_tick <= 0;
		crc_check <= 0;
	endtask

	// idle bits covering the error flag, first one checked for flag level
	task errw(input lvl, input chk);
		for (int k = 0; k < 7; k++) begin
			bt(`CEC_FLD_IDLE, 0, 1, 1, 0);
			if (k == 0 && chk)
				cmp(tx_s, lvl);
		end
	endtask

	task done(input t);
		@(posedge pclk);
		frame_tx <= t;
		frame_done <= 1;
		@(posedge pclk);
		frame_done <= 0;
	endtask

	function automatic logic [32:0] cnt();
		return {1'b0, 8'h00, re[7:0], 7'h00, te[8:0]};
	endfunction

	// read monitor: oldest note against the returned word
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && qe.size() > 0) begin
			cmp({pslverr, prdata} & qm[0], qe[0] & qm[0]);
			void'(qe.pop_front());
			void'(qm.pop_front());
		end
	end

	initial begin
		r = $urandom(32'h4bbb);
		repeat (6) @(posedge pclk);
		presetn <= 1;
		rd(`CEC_ADDR_CTRL, 33'h2, all_m);
		rd(`CEC_ADDR_STATUS, 0, all_m);
		rd(`CEC_ADDR_COUNT, 0, all_m);
		rd(12'h010, {1'b1, 32'h0}, all_m);
		repeat (6) bt(`CEC_FLD_ARB, 0, 1, 0, 0);
		re = 1;
		errw(0, 1);
		bt(`CEC_FLD_EOF, 0, 1, 0, 0);
		re = 2;
		errw(0, 1);
		crc_calc <= r[14:0];
		crc_rx <= r[14:0] ^ 15'h1;
		bt(`CEC_FLD_CHK, 0, 1, 1, 1);
		re = 3;
		errw(0, 1);
		rd(`CEC_ADDR_COUNT, cnt(), all_m);
		rd(`CEC_ADDR_ERRS, 33'h0e, 33'h1f);
		wr(`CEC_ADDR_ERRS, 32'h1f);
		done(1);
		crc_rx <= r[14:0];
		for (int k = 0; k < 3; k++) begin
			bt(`CEC_FLD_CHK, 0, 1, 1, 1);
			bt(`CEC_FLD_ACK, 0, 1, 1, 0);
			cmp(tx_s, 0);
			done(0);
		end
		re = 0;
		rd(`CEC_ADDR_COUNT, cnt(), all_m);
		ack_en <= 0;
		bt(`CEC_FLD_ACK, 1, 1, 1, 0);
		te = 8;
		errw(0, 1);
		rd(`CEC_ADDR_ERRS, 33'h10, 33'h1f);
		wr(`CEC_ADDR_ERRS, 32'h1f);
		ack_en <= 1;
		done(0);
		bt(`CEC_FLD_ACK, 1, 1, 1, 0);
		done(1);
		te = 7;
		rd(`CEC_ADDR_COUNT, cnt(), all_m);
		bt(`CEC_FLD_IDLE, 0, 1, 1, 0);
		for (int k = 0; k < 7; k++) begin
			bt(`CEC_FLD_ARB, 1, 1, 1, 0);
			if (k == 5)
				cmp({hold_s, rxv_s, tx_s}, 3'b100);
		end
		bt(`CEC_FLD_ACK, 1, 1, 1, 0);
		done(1);
		te = 6;
		wr(`CEC_ADDR_CTRL, 32'h3);
		rd(`CEC_ADDR_COUNT, cnt(), all_m);
		while (te <= 255) begin
			old = te;
			bt(`CEC_FLD_CHK, 1, 1, 0, 0);
			te += 8;
			errw(old > 127, (old > 127) == (te > 127) && te <= 255);
			if (old <= 127 && te > 127) begin
				rd(`CEC_ADDR_STATUS, 33'h9, 33'hf);
				ack_en <= 0;
				bt(`CEC_FLD_ACK, 1, 1, 1, 0);
				errw(1, 1);
				rd(`CEC_ADDR_COUNT, cnt(), all_m);
				ack_en <= 1;
			end
		end
		rd(`CEC_ADDR_STATUS, 33'ha, 33'hf);
		rd(`CEC_ADDR_COUNT, cnt(), all_m);
		bt(`CEC_FLD_CHK, 1, 0, 1, 0);
		cmp({tx_s, rxv_s}, 2'b10);
		wr(`CEC_ADDR_CTRL, 32'h3);
		te = 0;
		rd(`CEC_ADDR_STATUS, 0, st_m);
		rd(`CEC_ADDR_COUNT, 0, all_m);
		rd(`CEC_ADDR_ERRS, 33'h11, 33'h1f);
		stop_test;
	end

	initial begin
		repeat (50000) @(posedge pclk);
		miscompares++;
		stop_test;
	end
endmodule

bind cec_top cec_chk u_chk (.pclk(pclk), .presetn(presetn), .bit_tick(bit_tick),
	.field(field), .frame_tx(frame_tx), .crc_check(crc_check), .crc_calc(crc_calc),
	.crc_rx(crc_rx), .tx_hold(tx_hold), .rx_valid(rx_valid), .frame_abort(frame_abort),
	.retx_req(retx_req), .rx_bit(rx_bit), .can_tx(can_tx));
`default_nettype wire
